/* rtl/evp_core.sv */
// exception arbiter and vector selector with AHB-Lite registers
//
// Decided for this implementation: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
module evp_core
   import evp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire evp_nm_src_t nm_src_i,
   input wire logic nonmaskable_request_pin_n_i,
   input wire logic ext_irq_n_i,
   input wire logic [NUM_PERIPH-1:0] periph_req_i,
   input wire logic svc_start_i,
   output logic req_pending_o,
   output evp_fetch_t vector_o,
   output logic vector_valid_o
);

   // register state
   logic glob_ff;
   logic pin_mask_ff;
   logic [7:0] elev_ff;
   logic [20:0] en_ff;
   logic pin_edge_only_ff;
   logic clock_monitor_enable_ff;
   logic forced_monitor_enable_ff;
   // bus state
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] hrdata_ff;
   // pin synchronisers
   logic nmi_s1_ff;
   logic nmi_s2_ff;
   logic irq_s1_ff;
   logic irq_s2_ff;
   logic irq_s3_ff;
   // request and vector state
   logic edge_ff;
   logic por_ff;
   logic [15:0] vector_ff;
   logic valid_ff;
   // combinational
   logic fall_det;
   logic ext_req;
   logic [20:0] mask_raw;
   logic [20:0] mask_act;
   logic mask_any;
   logic [4:0] promo_idx;
   logic promo_ok;
   logic promo_hit;
   logic [4:0] win_idx;
   logic cm_req;
   logic pin_req;
   logic nm_any;
   logic req_any;
   logic take_ext;
   logic [7:0] nxt_low;
   logic addr_ok;
   logic [31:0] rd_word;

   // address decode shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // lowest set index, i.e. highest vector address first
   function automatic logic [4:0] first_set(input logic [20:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = MSK_SLOTS - 1; i >= 0; i--)
      begin
         if (v[i])
            r = 5'(i);
      end
      return r;
   endfunction

   // slot index to vector low byte, independent of promotion
   function automatic logic [7:0] slot_vec(input logic [4:0] k);
      return 8'(MSK_TOP - {2'b00, k, 1'b0});
   endfunction

   // bus: zero wait, always OKAY
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_ff;
   assign addr_ok = hsel_i && htrans_i[1] && hready_i;

   // address phase capture; read data prepared for the data phase
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
         hrdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= addr_ok && hwrite_i;
         if (addr_ok)
            wr_addr_ff <= haddr_i[7:0];
         if (addr_ok && !hwrite_i)
            hrdata_ff <= rd_word;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (hit(haddr_i[7:0], OFS_MASK))
         rd_word = {30'h0, pin_mask_ff, glob_ff};
      else if (hit(haddr_i[7:0], OFS_ELEV))
         rd_word = {24'h00_0000, elev_ff};
      else if (hit(haddr_i[7:0], OFS_EN))
         rd_word = {11'h000, en_ff};
      else if (hit(haddr_i[7:0], OFS_CFG))
         rd_word = {29'h0, forced_monitor_enable_ff, clock_monitor_enable_ff, pin_edge_only_ff};
      else if (hit(haddr_i[7:0], OFS_STAT))
         rd_word = {13'h0000, por_ff, edge_ff, req_any, vector_ff};
      else if (hit(haddr_i[7:0], OFS_PEND))
         rd_word = {11'h000, mask_raw};
   end

   // mask flags: software may write at any time
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         glob_ff <= RST_GLOB;
         pin_mask_ff <= RST_XMASK;
      end
      else if (wr_pend_ff && hit(wr_addr_ff, OFS_MASK))
      begin
         glob_ff <= hwdata_i[MASK_I_BIT];
         pin_mask_ff <= hwdata_i[MASK_X_BIT];
      end
   end

   // elevation register locked while maskable sources are live
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         elev_ff <= RST_ELEV;
      else if (wr_pend_ff && hit(wr_addr_ff, OFS_ELEV) && glob_ff)
         elev_ff <= hwdata_i[7:0];
   end

   // local enables and configuration
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         en_ff <= RST_EN;
         {forced_monitor_enable_ff, clock_monitor_enable_ff, pin_edge_only_ff} <= RST_CFG;
      end
      else if (wr_pend_ff)
      begin
         if (hit(wr_addr_ff, OFS_EN))
            en_ff <= hwdata_i[20:0];
         if (hit(wr_addr_ff, OFS_CFG))
         begin
            pin_edge_only_ff <= hwdata_i[CFG_EDGE_BIT];
            clock_monitor_enable_ff <= hwdata_i[CFG_CME_BIT];
            forced_monitor_enable_ff <= hwdata_i[CFG_FORCED_MONITOR_ENABLE_BIT];
         end
      end
   end

   // two-stage synchronisers; third stage only for edge detect
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         nmi_s1_ff <= 1'b1;
         nmi_s2_ff <= 1'b1;
         irq_s1_ff <= 1'b1;
         irq_s2_ff <= 1'b1;
         irq_s3_ff <= 1'b1;
      end
      else
      begin
         nmi_s1_ff <= nonmaskable_request_pin_n_i;
         nmi_s2_ff <= nmi_s1_ff;
         irq_s1_ff <= ext_irq_n_i;
         irq_s2_ff <= irq_s1_ff;
         irq_s3_ff <= irq_s2_ff;
      end
   end

   // falling edge of the synchronised pin
   assign fall_det = irq_s3_ff && !irq_s2_ff;

   // edge latch: a new edge beats the service clear
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         edge_ff <= 1'b0;
      else if (fall_det && pin_edge_only_ff)
         edge_ff <= 1'b1;
      else if (!pin_edge_only_ff)
         edge_ff <= 1'b0;
      else if (svc_start_i && take_ext)
         edge_ff <= 1'b0;
   end

   // level mode follows the pin, edge mode the latch
   assign ext_req = pin_edge_only_ff ? edge_ff : !irq_s2_ff;

   // maskable requests: reserved slots unwired, then enables and mask
   assign mask_raw = {periph_req_i, ext_req} & MSK_WIRED;
   assign mask_act = mask_raw & en_ff & {MSK_SLOTS{!glob_ff}};
   assign mask_any = |mask_act;

   // elevation value to slot; odd or out-of-range values promote nothing
   always_comb
   begin
      promo_idx = 5'(8'(MSK_TOP - elev_ff) >> 1);
      promo_ok = (elev_ff <= MSK_TOP) && (elev_ff >= MSK_BOT) && !elev_ff[0];
      if (promo_ok)
         promo_ok = MSK_WIRED[promo_idx];
   end

   // promoted slot first, rest in default descending order
   assign promo_hit = promo_ok && mask_act[promo_idx];
   assign win_idx = promo_hit ? promo_idx : first_set(mask_act);

   // gated non-maskable requests
   assign cm_req = nm_src_i.clkmon_fail && (clock_monitor_enable_ff || forced_monitor_enable_ff);
   assign pin_req = !nmi_s2_ff && !pin_mask_ff;

   // fixed hierarchy: non-maskable over maskable, trap as fallback
   always_comb
   begin
      nm_any = 1'b1;
      nxt_low = VEC_TRAP;
      if (por_ff)
         nxt_low = VEC_RESET;
      else if (cm_req)
         nxt_low = VEC_CLKMON;
      else if (nm_src_i.watchdog_timeout)
         nxt_low = VEC_WDOG;
      else if (nm_src_i.illegal_op)
         nxt_low = VEC_TRAP;
      else if (nm_src_i.soft_trap_op)
         nxt_low = VEC_SOFT;
      else if (pin_req)
         nxt_low = VEC_PIN;
      else
      begin
         nm_any = 1'b0;
         if (mask_any)
            nxt_low = slot_vec(win_idx);
      end
   end

   assign take_ext = !nm_any && mask_any && (win_idx == 5'h00);
   assign req_any = nm_any || mask_any;
   assign req_pending_o = req_any;

   // reset cause held until the reset vector is taken
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         por_ff <= 1'b1;
      else if (svc_start_i)
         por_ff <= 1'b0;
   end

   // vector captured when the core opens a service sequence
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         vector_ff <= {VEC_PAGE, VEC_RESET};
         valid_ff <= 1'b0;
      end
      else
      begin
         valid_ff <= svc_start_i;
         if (svc_start_i)
            vector_ff <= {VEC_PAGE, nxt_low};
      end
   end

   // even byte holds the high half of the vector
   assign vector_o.hi_addr = vector_ff;
   assign vector_o.lo_addr = {vector_ff[15:1], 1'b1};
   assign vector_valid_o = valid_ff;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_vec_top_page: assert property (valid_ff |-> vector_ff[15:7] == 9'h1FF)
      else $error("vector outside top 128 bytes");

   a_nm_slots_high: assert property (svc_start_i && nm_any |=> vector_ff[7:0] >= VEC_PIN)
      else $error("non-maskable source below its slots");

   a_por_first: assert property (svc_start_i && por_ff |=> vector_ff == {VEC_PAGE, VEC_RESET} && !por_ff)
      else $error("reset vector not taken first");

   a_clkmon_gate: assert property (svc_start_i && !por_ff && cm_req |=> vector_ff[7:0] == VEC_CLKMON)
      else $error("clock monitor vector wrong");

   a_pin_masked: assert property (svc_start_i && pin_mask_ff |=> vector_ff[7:0] != VEC_PIN)
      else $error("masked pin took its vector");

   a_soft_vec: assert property (svc_start_i && nm_src_i.soft_trap_op && !por_ff && !cm_req
      && !nm_src_i.watchdog_timeout && !nm_src_i.illegal_op |=> vector_ff[7:0] == VEC_SOFT)
      else $error("soft trap vector wrong");

   // checked at the vector, so a broken mask gate cannot hide behind mask_act
   a_mask_gates: assert property (svc_start_i && glob_ff && !nm_any |=> vector_ff[7:0] == VEC_TRAP)
      else $error("maskable source passed global mask");

   a_reserved_off: assert property (valid_ff |-> vector_ff[7:0] != 8'hD4 && vector_ff[7:0] != 8'hCE)
      else $error("reserved slot became active");

   a_elev_locked: assert property (wr_pend_ff && hit(wr_addr_ff, OFS_ELEV) && !glob_ff |=> $stable(elev_ff))
      else $error("elevation written while unmasked");

   a_promo_wins: assert property (svc_start_i && !nm_any && promo_hit |=> vector_ff == {VEC_PAGE, $past(elev_ff)})
      else $error("promoted source not chosen");

   a_default_order: assert property (svc_start_i && !nm_any && !promo_hit
      && !mask_act[0] && mask_act[1]
      |=> vector_ff[7:0] == 8'(MSK_TOP - 8'h02))
      else $error("default order broken");

   // back-to-back services are legal, so only the pulse itself is checked
   a_trap_fallback: assert property (svc_start_i && !req_any |=> vector_ff[7:0] == VEC_TRAP && valid_ff)
      else $error("empty service missed trap vector");

   a_edge_clear: assert property (svc_start_i && take_ext && pin_edge_only_ff && !fall_det |=> !edge_ff)
      else $error("edge latch not cleared on service");

   a_edge_set_wins: assert property (fall_det && pin_edge_only_ff |=> edge_ff)
      else $error("edge lost to service clear");

   a_level_no_latch: assert property (!pin_edge_only_ff |=> !edge_ff)
      else $error("edge latch set in level mode");

   a_fetch_pair: assert property (svc_start_i |=> valid_ff
      && vector_o.lo_addr == vector_o.hi_addr + 16'h0001)
      else $error("fetch pair not consecutive");

   a_wdog_vec: assert property (svc_start_i && !por_ff && !cm_req && nm_src_i.watchdog_timeout
      |=> vector_ff[7:0] == VEC_WDOG)
      else $error("watchdog vector wrong");

   a_trap_vec: assert property (svc_start_i && !por_ff && !cm_req && !nm_src_i.watchdog_timeout
      && nm_src_i.illegal_op |=> vector_ff[7:0] == VEC_TRAP)
      else $error("trap vector wrong");

   a_pin_vec: assert property (svc_start_i && pin_req && !por_ff && !cm_req && !nm_src_i.watchdog_timeout
      && !nm_src_i.illegal_op && !nm_src_i.soft_trap_op |=> vector_ff[7:0] == VEC_PIN)
      else $error("unmasked pin vector wrong");

   a_elev_write: assert property (wr_pend_ff && hit(wr_addr_ff, OFS_ELEV) && glob_ff
      |=> elev_ff == 8'($past(hwdata_i)))
      else $error("elevation write lost while masked");

   c_promo_taken: cover property (svc_start_i && promo_hit && !nm_any);
   c_trap_empty: cover property (svc_start_i && !req_any);
   c_edge_caught: cover property (fall_det && pin_edge_only_ff ##[1:20] svc_start_i && take_ext);
   c_elev_refused: cover property (wr_pend_ff && hit(wr_addr_ff, OFS_ELEV) && !glob_ff);

endmodule // evp_core

/* rtl/evp_pkg.sv */
// package: constants and types for exception priority and vectoring
package evp_pkg;

   // vector page and low bytes of the fixed slots
   localparam logic [7:0] VEC_PAGE = 8'hFF;
   localparam logic [7:0] VEC_RESET = 8'hFE;
   localparam logic [7:0] VEC_CLKMON = 8'hFC;
   localparam logic [7:0] VEC_WDOG = 8'hFA;
   localparam logic [7:0] VEC_TRAP = 8'hF8;
   localparam logic [7:0] VEC_SOFT = 8'hF6;
   localparam logic [7:0] VEC_PIN = 8'hF4;

   // maskable slots: slot k sits at MSK_TOP - 2k
   localparam logic [7:0] MSK_TOP = 8'hF2;
   localparam logic [7:0] MSK_BOT = 8'hCA;
   localparam int MSK_SLOTS = 21;
   localparam int NUM_PERIPH = 20;
   // slots D4 (15) and CE (18) are reserved, left unwired
   localparam logic [20:0] MSK_WIRED = 21'h1B_7FFF;
   localparam int SLOT_PA_OVF = 11;
   localparam int SLOT_PA_EDGE = 12;
   localparam int SLOT_SERIAL = 13;
   localparam int SLOT_MODULUS = 19;
   localparam int SLOT_PB_OVF = 20;

   // register byte offsets
   localparam logic [7:0] OFS_MASK = 8'h00;
   localparam logic [7:0] OFS_ELEV = 8'h04;
   localparam logic [7:0] OFS_EN = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_PEND = 8'h14;

   // field positions
   localparam int MASK_I_BIT = 0;
   localparam int MASK_X_BIT = 1;
   localparam int CFG_EDGE_BIT = 0;
   localparam int CFG_CME_BIT = 1;
   localparam int CFG_FORCED_MONITOR_ENABLE_BIT = 2;

   // reset values
   localparam logic RST_GLOB = 1'b1;
   localparam logic RST_XMASK = 1'b1;
   localparam logic [7:0] RST_ELEV = 8'hF2;
   localparam logic [20:0] RST_EN = 21'h00_0000;
   localparam logic [2:0] RST_CFG = 3'h0;

   // non-maskable request bundle from core and watchdog
   typedef struct packed {
      logic clkmon_fail;
      logic watchdog_timeout;
      logic illegal_op;
      logic soft_trap_op;
   } evp_nm_src_t;

   // byte addresses of one vector fetch
   typedef struct packed {
      logic [15:0] hi_addr;
      logic [15:0] lo_addr;
   } evp_fetch_t;

endpackage

/* verif/evp_core_model.sv */
// core sequencer model: issues service starts and fetches vectors
`timescale 1ns/1ps
module evp_core_model
   import evp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   output logic svc_start_o,
   input wire evp_fetch_t vector_i,
   input wire logic vector_valid_i
);
   // idle until the bench asks for a service sequence
   initial svc_start_o = 1'b0;

   // one-cycle start pulse, then wait for the fetch pair
   // starts even with no request pending, like a real core
   task automatic service(output evp_fetch_t v);
      int n;
      svc_start_o <= 1'b1;
      @(posedge sys_clk_i);
      svc_start_o <= 1'b0;
      n = 0;
      // bounded wait; a missing pulse shows up as a bad vector
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (vector_valid_i !== 1'b1 && n < 8 && reset_n_i === 1'b1);
      v = vector_i; // high byte address, then low byte address
   endtask
endmodule // evp_core_model

/* verif/tb.sv */
// self-checking bench for the exception arbiter and vector selector
`timescale 1ns/1ps
module tb;
   import evp_pkg::*;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hready;
   logic hresp;
   evp_nm_src_t nm_src = 4'h0;
   logic xpin_n = 1'b1;
   logic ext_n = 1'b1;
   logic [19:0] preq = 20'h0_0000;
   logic svc;
   logic req_pend;
   evp_fetch_t vec;
   logic vval;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int k;
   logic [31:0] rd;
   logic [7:0] lo;
   logic [7:0] nm_exp [4] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4};
   int slots [7] = '{11, 12, 13, 19, 20, 15, 18};

   // free-running core clock, 10 ns
   always #5 sys_clk_i = ~sys_clk_i;

   evp_core uut (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
      .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .nm_src_i(nm_src), .nonmaskable_request_pin_n_i(xpin_n), .ext_irq_n_i(ext_n),
      .periph_req_i(preq), .svc_start_i(svc), .req_pending_o(req_pend),
      .vector_o(vec), .vector_valid_o(vval)
   );

   evp_core_model model (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .svc_start_o(svc),
      .vector_i(vec), .vector_valid_i(vval)
   );

   // verdict and end of run, shared by the main flow and the timeout
   task print_verdict();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // address phase held until hready, then data phase until hready
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge sys_clk_i);
      while (hready !== 1'b1) @(posedge sys_clk_i);
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0000_0000;
      @(posedge sys_clk_i);
      while (hready !== 1'b1) @(posedge sys_clk_i);
      rd = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // one service sequence; expect FF:lo then FF:lo+1
   task svc_chk(input logic [7:0] l);
      evp_fetch_t v;
      model.service(v);
      chk({31'h0, vval}, 32'h0000_0001);
      chk({v.hi_addr, v.lo_addr}, {8'hFF, l, 8'hFF, l | 8'h01});
   endtask

   // hang guard, well above the expected run length
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         print_verdict();
      end
   end

   initial
   begin
      wait_cyc(6);
      reset_n_i <= 1'b1;
      @(posedge sys_clk_i);
      bus(1'b0, OFS_MASK, 32'h0);
      chk(rd, 32'h0000_0003);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0000_0000);
      svc_chk(8'hFE);
      // every fixed source at once, pin unmasked
      wr(OFS_MASK, 32'h0000_0000);
      nm_src <= 4'hF;
      xpin_n <= 1'b0;
      wr(OFS_CFG, 32'h0000_0002);
      wait_cyc(4);
      svc_chk(8'hFC);
      wr(OFS_CFG, 32'h0000_0004);
      svc_chk(8'hFC);
      wr(OFS_CFG, 32'h0000_0000);
      svc_chk(8'hFA);
      // drop the highest source each step to walk down the order
      for (k = 0; k < 4; k++)
      begin
         nm_src <= 4'h7 >> k;
         @(posedge sys_clk_i);
         svc_chk(nm_exp[k]);
      end
      wr(OFS_MASK, 32'h0000_0002);
      wait_cyc(2);
      chk({31'h0, req_pend}, 32'h0000_0000);
      svc_chk(8'hF8);
      xpin_n <= 1'b1;
      // maskable: all peripherals asking, default order
      wr(OFS_EN, 32'h001F_FFFF);
      preq <= 20'hF_FFFF;
      wr(OFS_MASK, 32'h0000_0000);
      svc_chk(8'hF0);
      wr(OFS_MASK, 32'h0000_0001);
      svc_chk(8'hF8);
      wr(OFS_ELEV, 32'h0000_00D8);
      wr(OFS_MASK, 32'h0000_0000);
      svc_chk(8'hD8);
      wr(OFS_ELEV, 32'h0000_00CC);
      bus(1'b0, OFS_ELEV, 32'h0);
      chk(rd, 32'h0000_00D8);
      wr(OFS_EN, 32'h001F_DFFF);
      svc_chk(8'hF0);
      // named peripheral slots 11, 12, 13, 19 and 20 promoted over slot 1, reserved ones inert
      wr(OFS_EN, 32'h001F_FFFF);
      for (k = 0; k < 7; k++)
      begin
         lo = 8'hF2 - 8'(2 * slots[k]);
         wr(OFS_MASK, 32'h0000_0001);
         wr(OFS_ELEV, {24'h00_0000, lo});
         wr(OFS_MASK, 32'h0000_0000);
         preq <= (20'h0_0001 << (slots[k] - 1)) | 20'h0_0001;
         @(posedge sys_clk_i);
         if (slots[k] == 15 || slots[k] == 18)
            lo = 8'hF0;
         svc_chk(lo);
      end
      // external pin, edge mode then level mode
      preq <= 20'h0_0000;
      wr(OFS_EN, 32'h0000_0001);
      wr(OFS_CFG, 32'h0000_0001);
      ext_n <= 1'b0;
      wait_cyc(2);
      ext_n <= 1'b1;
      wait_cyc(5);
      svc_chk(8'hF2);
      svc_chk(8'hF8);
      wr(OFS_CFG, 32'h0000_0000);
      ext_n <= 1'b0;
      wait_cyc(4);
      svc_chk(8'hF2);
      svc_chk(8'hF2);
      ext_n <= 1'b1;
      wait_cyc(2);
      print_verdict();
   end
endmodule // tb
